//--- hw/dtc_defs.svh
// register indices, field positions, reset values and counts of the dual 8-bit timer
`ifndef DTC_DEFS_SVH
`define DTC_DEFS_SVH
`define DTC_IDX_CLKSEL0 32'hFFFFF5C4
`define DTC_IDX_CLKSEL1 32'hFFFFF5C5
`define DTC_IDX_MODE0 32'hFFFFF5C6
`define DTC_IDX_MODE1 32'hFFFFF5C7
`define DTC_IDX_CMP0 32'hFFFFF5C0
`define DTC_IDX_CMP1 32'hFFFFF5C1
`define DTC_IDX_CNT0 32'hFFFFF5C8
`define DTC_IDX_CNT1 32'hFFFFF5C9
`define DTC_IDX_CCNT 32'hFFFFF5CA
`define DTC_IDX_CCMP 32'hFFFFF5CB
`define DTC_DEC_MSB 9
`define DTC_ADDR_W 12
`define DTC_CLKSEL_RST 8'h00
`define DTC_MODE_RST 8'h00
`define DTC_CMP_RST 8'h00
`define DTC_CNT_RST 8'h00
`define DTC_CNT_MAX 8'hFF
`define DTC_CNT_ONE 8'h01
`define DTC_PRE_RST 8'h00
`define DTC_MC_EN 7
`define DTC_MC_PWM 6
`define DTC_MC_CASC 4
`define DTC_MC_LVS 3
`define DTC_MC_LVR 2
`define DTC_MC_LVL 1
`define DTC_MC_TOE 0
`define DTC_MC_STORE 8'hD3
`define DTC_TAP_DIV4 1
`define DTC_TAP_DIV64 5
`define DTC_TAP_DIV256 7
`define DTC_RESP_OKAY 2'h0
`define DTC_RESP_SLVERR 2'h2
`endif

//--- hw/dtc_pkg.sv
// types shared by the dual 8-bit timer files
package dtc_pkg;
  typedef logic [7:0] dtc_byte_t;
  typedef enum logic [2:0] {
    DTC_CS_FALL = 3'h0,
    DTC_CS_RISE = 3'h1,
    DTC_CS_FXX = 3'h2,
    DTC_CS_DIV2 = 3'h3,
    DTC_CS_DIV4 = 3'h4,
    DTC_CS_DIV64 = 3'h5,
    DTC_CS_DIV256 = 3'h6,
    DTC_CS_OTHER = 3'h7
  } dtc_clksel_t;
endpackage

//--- hw/dtc_chan_if.sv
// control and status bundle between the timer top and one counter channel
`timescale 1ns/1ns
interface dtc_chan_if;
  import dtc_pkg::*;
  logic tick;
  logic en;
  logic clr;
  logic pwm;
  logic lvl;
  logic toe;
  logic ff_set;
  logic ff_rst;
  logic match_ev;
  logic ovf_ev;
  dtc_byte_t count;
  logic wrap;
  logic pin;
  modport ctl (output tick, en, clr, pwm, lvl, toe, ff_set, ff_rst, match_ev, ovf_ev, input count, wrap, pin);
  modport chan (input tick, en, clr, pwm, lvl, toe, ff_set, ff_rst, match_ev, ovf_ev, output count, wrap, pin);
endinterface

//--- hw/dtc_pin_sync.sv
// three-stage pin synchroniser with agreed-level edge detection
`timescale 1ns/1ns
module dtc_pin_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin,
  output logic rise,
  output logic fall
);
  logic s1_q, s2_q, s3_q, lvl_q, rise_q, fall_q;
  // a change counts only once stages two and three agree, which filters one-cycle glitches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {s1_q, s2_q, s3_q, lvl_q, rise_q, fall_q} <= 6'h00;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) lvl_q <= s3_q;
      rise_q <= (s2_q == s3_q) & s3_q & ~lvl_q;
      fall_q <= (s2_q == s3_q) & ~s3_q & lvl_q;
    end
  end
  assign rise = rise_q;
  assign fall = fall_q;
endmodule // dtc_pin_sync

//--- hw/dtc_channel.sv
// one 8-bit up counter with its timer output flip-flop
`timescale 1ns/1ns
module dtc_channel
  import dtc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  dtc_chan_if.chan ch
);
  `include "dtc_defs.svh"
  dtc_byte_t count_q;
  logic ff_q, pin_q;
  // clear wins over counting so a match step lands on zero, not on cmp+1
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= `DTC_CNT_RST;
    end else if (!ch.en || ch.clr) begin
      count_q <= `DTC_CNT_RST;
    end else if (ch.tick) begin
      count_q <= count_q + `DTC_CNT_ONE;
    end
  end
  assign ch.count = count_q;
  assign ch.wrap = ch.tick & ch.en & (count_q == `DTC_CNT_MAX);
  // output flip-flop: pwm drives active on overflow, inactive on match; otherwise toggle or force
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ff_q <= 1'b0;
      pin_q <= 1'b0;
    end else begin
      if (ch.pwm) begin
        if (!ch.en || ch.match_ev) ff_q <= 1'b0;
        else if (ch.ovf_ev) ff_q <= 1'b1;
      end else if (ch.ff_set) begin
        ff_q <= 1'b1;
      end else if (ch.ff_rst) begin
        ff_q <= 1'b0;
      end else if (ch.match_ev && ch.lvl) begin
        ff_q <= ~ff_q;
      end
      pin_q <= ch.toe & (ch.pwm ? (ff_q ^ ch.lvl) : ff_q);
    end
  end
  assign ch.pin = pin_q;
endmodule // dtc_channel

//--- hw/dtc_timer_top.sv
// dual 8-bit timer/event counter with cascade mode behind an AXI4-Lite slave
//
// Contract
// - cascade select joins both channels into one 16-bit counter.
// - cascade supports interval, event counting and square wave at 16 bits.
// - each counter is read-only and steps once per selected count tick.
// - in cascade the count is readable only as one 16-bit word.
// - counter clears on reset, enable clear, and match in clear-start mode.
// - in cascade clearing the lower enable clears the whole 16-bit count.
// - outside pwm the counter is compared with compare and matches interrupt.
// - pwm overflow drives output active, compare match drives it inactive.
// - compare register is byte read/write and takes any 00H..FFH value.
// - cascade compares 16 bits; only the lower interrupt fires.
// - clock select picks clock and edge, byte access, resets to 00H.
// - select codes: fall, rise, fxx, /2, /4, /64, /256, other timer.
// - in cascade the upper clock select is ignored; lower clock counts.
// - enable bit 7 starts counting; clearing it clears and stops.
// - mode select 0 is clear-and-start on match, 1 is pwm.
// - cascade bit in upper mode control joins channels; lower bit is zero.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module dtc_timer_top
  import dtc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic event_input_pin0,
  input wire logic event_input_pin1,
  input wire logic other_timer_compare_irq,
  output logic timer_output_pin0,
  output logic timer_output_pin1,
  output logic lower_match_interrupt,
  output logic match_interrupt1
);
  `include "dtc_defs.svh"

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [`DTC_ADDR_W-1:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  dtc_byte_t clksel0_q, clksel1_q, mode0_q, mode1_q, cmp0_q, cmp1_q;
  dtc_byte_t pre_q;
  logic irq0_q, irq1_q;
  logic rise0, fall0, rise1, fall1;
  logic tick0, tick1;
  logic casc, en0, en1, pwm0, pwm1;
  logic eq0, eq1, ev0, ev1;
  logic wr_go, ar_hs;
  logic [`DTC_DEC_MSB:0] wsel, rsel;
  logic w_cs0, w_cs1, w_md0, w_md1, w_cp0, w_cp1, w_ccp, w_hit;
  logic r_cs0, r_cs1, r_md0, r_md1, r_cp0, r_cp1, r_ct0, r_ct1, r_cct, r_ccp, r_hit;
  dtc_byte_t wbyte0, wbyte1;
  logic [31:0] rmux;

  dtc_chan_if c0 ();
  dtc_chan_if c1 ();

  ////////////////////////////////////////////////////////////////////////////
  // event pins and prescaler

  dtc_pin_sync u_sync0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(event_input_pin0),
    .rise(rise0),
    .fall(fall0)
  );

  dtc_pin_sync u_sync1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(event_input_pin1),
    .rise(rise1),
    .fall(fall1)
  );

  // free-running divider; each tap pulses once per period so the counters stay on aclk
  always_ff @(posedge aclk) begin
    if (!aresetn) pre_q <= `DTC_PRE_RST;
    else pre_q <= pre_q + `DTC_CNT_ONE;
  end

  // count tick from the three clock select bits
  function automatic logic sel_tick(input dtc_byte_t sel, input logic rise, input logic fall,
                                    input dtc_byte_t pre, input logic other);
    logic t;
    t = 1'b0;
    unique case (dtc_clksel_t'(sel[2:0]))
      DTC_CS_FALL: t = fall;
      DTC_CS_RISE: t = rise;
      DTC_CS_FXX: t = 1'b1;
      DTC_CS_DIV2: t = pre[0];
      DTC_CS_DIV4: t = &pre[`DTC_TAP_DIV4:0];
      DTC_CS_DIV64: t = &pre[`DTC_TAP_DIV64:0];
      DTC_CS_DIV256: t = &pre[`DTC_TAP_DIV256:0];
      DTC_CS_OTHER: t = other;
    endcase
    return t;
  endfunction

  assign tick0 = sel_tick(clksel0_q, rise0, fall0, pre_q, other_timer_compare_irq);
  assign tick1 = sel_tick(clksel1_q, rise1, fall1, pre_q, other_timer_compare_irq);

  ////////////////////////////////////////////////////////////////////////////
  // mode decode and compare

  assign casc = mode1_q[`DTC_MC_CASC];
  assign en0 = mode0_q[`DTC_MC_EN];
  assign en1 = casc ? en0 : mode1_q[`DTC_MC_EN];
  assign pwm0 = mode0_q[`DTC_MC_PWM];
  assign pwm1 = casc ? pwm0 : mode1_q[`DTC_MC_PWM];
  assign eq0 = (c0.count == cmp0_q);
  assign eq1 = (c1.count == cmp1_q);
  // cascade compares the full 16 bits and routes the event to the lower channel only
  assign ev0 = tick0 & en0 & eq0 & (~casc | eq1);
  assign ev1 = ~casc & tick1 & en1 & eq1;

  // lower channel
  assign c0.tick = tick0;
  assign c0.en = en0;
  assign c0.clr = ev0 & ~pwm0;
  assign c0.pwm = pwm0;
  assign c0.lvl = mode0_q[`DTC_MC_LVL];
  assign c0.toe = mode0_q[`DTC_MC_TOE];
  assign c0.ff_set = w_md0 & wbyte0[`DTC_MC_LVS] & ~wbyte0[`DTC_MC_LVR];
  assign c0.ff_rst = w_md0 & wbyte0[`DTC_MC_LVR] & ~wbyte0[`DTC_MC_LVS];
  assign c0.match_ev = ev0;
  assign c0.ovf_ev = casc ? c1.wrap : c0.wrap;

  // upper channel steps on the lower wrap in cascade, its own select is ignored there
  assign c1.tick = casc ? (c0.wrap & ~c0.clr) : tick1;
  assign c1.en = en1;
  assign c1.clr = casc ? c0.clr : (ev1 & ~pwm1);
  assign c1.pwm = pwm1;
  assign c1.lvl = mode1_q[`DTC_MC_LVL];
  assign c1.toe = mode1_q[`DTC_MC_TOE];
  assign c1.ff_set = w_md1 & wbyte0[`DTC_MC_LVS] & ~wbyte0[`DTC_MC_LVR];
  assign c1.ff_rst = w_md1 & wbyte0[`DTC_MC_LVR] & ~wbyte0[`DTC_MC_LVS];
  assign c1.match_ev = ev1;
  assign c1.ovf_ev = c1.wrap;

  dtc_channel u_ch0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .ch(c0.chan)
  );

  dtc_channel u_ch1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .ch(c1.chan)
  );

  // interrupts are single pulses taken in the clearing step; pwm mode raises none
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq0_q <= 1'b0;
      irq1_q <= 1'b0;
    end else begin
      irq0_q <= ev0 & ~pwm0;
      irq1_q <= ev1 & ~pwm1;
    end
  end

  assign lower_match_interrupt = irq0_q;
  assign match_interrupt1 = irq1_q;
  assign timer_output_pin0 = c0.pin;
  assign timer_output_pin1 = c1.pin;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path

  assign wr_go = ~awready_q & ~wready_q & ~bvalid_q;
  assign wsel = waddr_q[`DTC_ADDR_W-1:2];
  assign w_cs0 = wr_go & (wsel == 10'(`DTC_IDX_CLKSEL0)) & wstrb_q[0];
  assign w_cs1 = wr_go & (wsel == 10'(`DTC_IDX_CLKSEL1)) & wstrb_q[0];
  assign w_md0 = wr_go & (wsel == 10'(`DTC_IDX_MODE0)) & wstrb_q[0];
  assign w_md1 = wr_go & (wsel == 10'(`DTC_IDX_MODE1)) & wstrb_q[0];
  assign w_cp0 = wr_go & (wsel == 10'(`DTC_IDX_CMP0)) & wstrb_q[0];
  assign w_cp1 = wr_go & (wsel == 10'(`DTC_IDX_CMP1)) & wstrb_q[0];
  assign w_ccp = wr_go & (wsel == 10'(`DTC_IDX_CCMP));
  // count registers are read-only, so a write there is an error answer
  assign w_hit = (wsel == 10'(`DTC_IDX_CLKSEL0)) | (wsel == 10'(`DTC_IDX_CLKSEL1))
               | (wsel == 10'(`DTC_IDX_MODE0)) | (wsel == 10'(`DTC_IDX_MODE1))
               | (wsel == 10'(`DTC_IDX_CMP0)) | (wsel == 10'(`DTC_IDX_CMP1))
               | (wsel == 10'(`DTC_IDX_CCMP));
  assign wbyte0 = wdata_q[7:0];
  assign wbyte1 = wdata_q[15:8];

  // address and data are caught independently; the write fires once both are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `DTC_RESP_OKAY;
      waddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= 4'h0;
    end else begin
      if (awready_q && s_axi_awvalid) begin
        awready_q <= 1'b0;
        waddr_q <= s_axi_awaddr[`DTC_ADDR_W-1:0];
      end
      if (wready_q && s_axi_wvalid) begin
        wready_q <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= w_hit ? `DTC_RESP_OKAY : `DTC_RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // register file; set/reset request bits of mode control are not stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clksel0_q <= `DTC_CLKSEL_RST;
      clksel1_q <= `DTC_CLKSEL_RST;
      mode0_q <= `DTC_MODE_RST;
      mode1_q <= `DTC_MODE_RST;
      cmp0_q <= `DTC_CMP_RST;
      cmp1_q <= `DTC_CMP_RST;
    end else begin
      if (w_cs0) clksel0_q <= {5'h00, wbyte0[2:0]};
      if (w_cs1) clksel1_q <= {5'h00, wbyte0[2:0]};
      if (w_md0) mode0_q <= wbyte0 & `DTC_MC_STORE & ~(8'h01 << `DTC_MC_CASC);
      if (w_md1) mode1_q <= wbyte0 & `DTC_MC_STORE;
      if (w_cp0 || (w_ccp && wstrb_q[0])) cmp0_q <= wbyte0;
      if (w_cp1) cmp1_q <= wbyte0;
      else if (w_ccp && wstrb_q[1]) cmp1_q <= wbyte1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path

  assign ar_hs = arready_q & s_axi_arvalid;
  assign rsel = s_axi_araddr[`DTC_ADDR_W-1:2];
  assign r_cs0 = (rsel == 10'(`DTC_IDX_CLKSEL0));
  assign r_cs1 = (rsel == 10'(`DTC_IDX_CLKSEL1));
  assign r_md0 = (rsel == 10'(`DTC_IDX_MODE0));
  assign r_md1 = (rsel == 10'(`DTC_IDX_MODE1));
  assign r_cp0 = (rsel == 10'(`DTC_IDX_CMP0));
  assign r_cp1 = (rsel == 10'(`DTC_IDX_CMP1));
  assign r_ct0 = (rsel == 10'(`DTC_IDX_CNT0));
  assign r_ct1 = (rsel == 10'(`DTC_IDX_CNT1));
  assign r_cct = (rsel == 10'(`DTC_IDX_CCNT));
  assign r_ccp = (rsel == 10'(`DTC_IDX_CCMP));
  assign r_hit = r_cs0 | r_cs1 | r_md0 | r_md1 | r_cp0 | r_cp1 | r_ct0 | r_ct1 | r_cct | r_ccp;

  // byte count views read zero in cascade so both halves always come from one sample
  assign rmux = ({32{r_cs0}} & {24'h000000, clksel0_q})
              | ({32{r_cs1}} & {24'h000000, clksel1_q})
              | ({32{r_md0}} & {24'h000000, mode0_q})
              | ({32{r_md1}} & {24'h000000, mode1_q})
              | ({32{r_cp0}} & {24'h000000, cmp0_q})
              | ({32{r_cp1}} & {24'h000000, cmp1_q})
              | ({32{r_ct0 & ~casc}} & {24'h000000, c0.count})
              | ({32{r_ct1 & ~casc}} & {24'h000000, c1.count})
              | ({32{r_cct}} & {16'h0000, c1.count, c0.count})
              | ({32{r_ccp}} & {16'h0000, cmp1_q, cmp0_q});

  // one read in flight; data are sampled in the cycle the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `DTC_RESP_OKAY;
    end else if (ar_hs) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rmux;
      rresp_q <= r_hit ? `DTC_RESP_OKAY : `DTC_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
endmodule // dtc_timer_top

//--- verif/dtc_timer_monitor.sv
// concurrent checks on the ports of the dual 8-bit timer
`timescale 1ns/1ns
`include "dtc_defs.svh"
module dtc_timer_monitor
  import dtc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_output_pin0,
  input wire logic lower_match_interrupt,
  input wire logic match_interrupt1
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  // bus handshakes taken at one edge
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // write answer comes within two edges of the take
  property p_wr_answer; s_wr_take |-> ##[1:2] s_axi_bvalid; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write response late");
  property p_rd_answer; s_rd_take |=> s_axi_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read data late");
  // a second request must wait for the pending answer
  property p_aw_blocked; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_aw_blocked: assert property (p_aw_blocked) else $error("write taken while response pending");
  property p_ar_blocked; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_blocked: assert property (p_ar_blocked) else $error("read taken while data pending");
  property p_rd_once; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_rd_once: assert property (p_rd_once) else $error("read data repeated");
  // a hole in the map answers an error and zero data
  property p_unmapped;
    s_rd_take and (s_axi_araddr[11:2] == 10'h3FF) |=> (s_axi_rresp == `DTC_RESP_SLVERR) && (s_axi_rdata == 32'h0);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  ////////////////////////////////////////////////////////////////////////////////
  // match interrupts are single-cycle pulses
  property p_irq0_pulse; lower_match_interrupt |=> !lower_match_interrupt; endproperty
  a_irq0_pulse: assert property (p_irq0_pulse) else $error("lower match pulse too long");
  property p_irq1_pulse; match_interrupt1 |=> !match_interrupt1; endproperty
  a_irq1_pulse: assert property (p_irq1_pulse) else $error("upper match pulse too long");
  // outputs come out of reset quiet
  property p_rst_quiet;
    $rose(aresetn) |-> !lower_match_interrupt && !match_interrupt1 && !timer_output_pin0 && !s_axi_bvalid;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
endmodule // dtc_timer_monitor

bind dtc_timer_top dtc_timer_monitor dtc_timer_monitor_i (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .timer_output_pin0(timer_output_pin0), .lower_match_interrupt(lower_match_interrupt),
  .match_interrupt1(match_interrupt1));

//--- verif/dtc_far_model.sv
// event pin source and other-timer interrupt source facing the timer
`timescale 1ns/1ns
module dtc_far_model (
  input wire logic aclk,
  output logic pin0,
  output logic pin1,
  output logic irq
);
  // pins idle low so no stray edge is seen at enable
  initial begin
    pin0 = 1'h0;
    pin1 = 1'h0;
    irq = 1'h0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // pulses wide enough to pass the pin synchroniser: one rise and one fall each
  task automatic pulse_pin(input int ch, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      if (ch == 0) pin0 <= 1'h1; else pin1 <= 1'h1;
      repeat (4) @(posedge aclk);
      if (ch == 0) pin0 <= 1'h0; else pin1 <= 1'h0;
      repeat (3) @(posedge aclk);
    end
  endtask
  // one-cycle compare pulses, spaced so each is a separate tick
  task automatic fire_irq(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      irq <= 1'h1;
      @(posedge aclk);
      irq <= 1'h0;
      repeat (2) @(posedge aclk);
    end
  endtask
endmodule // dtc_far_model

//--- verif/dual_8bit_timer_cascade_tb.sv
// self-checking bench for the dual 8-bit timer with cascade mode
`timescale 1ns/1ns
`include "dtc_defs.svh"
module dual_8bit_timer_cascade_tb;
  import dtc_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, ev0, ev1, oirq, pin0, pin1, irq0, irq1;
  logic [1:0] bresp, rresp;
  int n_fail = 0, total_checks = 0, irq1_cnt = 0;
  always #2 aclk = ~aclk;
  dtc_timer_top dtc_timer_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .event_input_pin0(ev0),
    .event_input_pin1(ev1), .other_timer_compare_irq(oirq), .timer_output_pin0(pin0),
    .timer_output_pin1(pin1), .lower_match_interrupt(irq0), .match_interrupt1(irq1));
  dtc_far_model dtc_far_model_i (.aclk(aclk), .pin0(ev0), .pin1(ev1), .irq(oirq));
  // upper channel pulses are counted as they come
  always @(posedge aclk) if (irq1 === 1'h1) irq1_cnt++;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  task automatic bail(input string nm);
    $display("wrong value %s expected answer seen none", nm);
    n_fail++;
    complete_run();
  endtask
  // one write: both channels offered together, each dropped once taken
  task automatic wr(input logic [31:0] idx, input logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    awaddr <= idx << 2;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (k = 0; k < 100; k++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'h0;
        break;
      end
    end
    if (k == 100) bail("write response");
  endtask
  task automatic rd(input logic [31:0] idx, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    araddr <= idx << 2;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (k = 0; k < 100; k++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'h0;
        break;
      end
    end
    if (k == 100) bail("read data");
  endtask
  task automatic wrc(input logic [31:0] idx, input logic [31:0] d);
    logic [1:0] r;
    wr(idx, d, r);
    chk("write resp", `DTC_RESP_OKAY, {30'h0, r});
  endtask
  task automatic rdc(input string nm, input logic [31:0] idx, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(idx, d, r);
    chk(nm, e, d);
  endtask
  // cycles until the next lower match pulse
  task automatic wait_irq(output int t);
    for (t = 1; t < 2000; t++) begin
      @(posedge aclk);
      if (irq0 === 1'h1) return;
    end
    bail("match pulse");
  endtask
  task automatic pin_wait(input logic v, output int t);
    for (t = 1; t < 2000; t++) begin
      @(posedge aclk);
      if (pin0 === v) return;
    end
    bail("output pin");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    rdc("clock select 0", `DTC_IDX_CLKSEL0, 32'h0);
    rdc("clock select 1", `DTC_IDX_CLKSEL1, 32'h0);
    rdc("count 0", `DTC_IDX_CNT0, 32'h0);
    wrc(`DTC_IDX_CMP0, 32'hFF);
    rdc("compare 0", `DTC_IDX_CMP0, 32'hFF);
    wr(`DTC_IDX_CNT0, 32'h55, r);
    chk("count write resp", `DTC_RESP_SLVERR, {30'h0, r});
    rdc("count 0 kept", `DTC_IDX_CNT0, 32'h0);
    rd(32'h3FF, d, r);
    chk("hole resp", `DTC_RESP_SLVERR, {30'h0, r});
    wrc(`DTC_IDX_MODE0, 32'h10);
    rdc("lower cascade bit", `DTC_IDX_MODE0, 32'h0);
    $display("test regs done");
  endtask
  // every internal tap against its exact match interval
  task automatic t_interval;
    dtc_clksel_t cs[5] = '{DTC_CS_FXX, DTC_CS_DIV2, DTC_CS_DIV4, DTC_CS_DIV64, DTC_CS_DIV256};
    logic [7:0] n[5] = '{8'h03, 8'h00, 8'h01, 8'h00, 8'h00};
    int e[5] = '{4, 2, 8, 64, 256};
    int t;
    for (int i = 0; i < 5; i++) begin
      wrc(`DTC_IDX_MODE0, 32'h0);
      wrc(`DTC_IDX_CLKSEL0, {29'h0, cs[i]});
      wrc(`DTC_IDX_CMP0, {24'h0, n[i]});
      wrc(`DTC_IDX_MODE0, 32'h80);
      wait_irq(t);
      wait_irq(t);
      chk("interval", e[i], t);
    end
    wrc(`DTC_IDX_MODE0, 32'h0);
    rdc("count after stop", `DTC_IDX_CNT0, 32'h0);
    $display("test interval done");
  endtask
  // edge and other-timer clocks count exactly the events given
  task automatic t_event;
    dtc_clksel_t cs[3] = '{DTC_CS_FALL, DTC_CS_RISE, DTC_CS_OTHER};
    int i1;
    for (int i = 0; i < 3; i++) begin
      wrc(`DTC_IDX_MODE0, 32'h0);
      wrc(`DTC_IDX_CLKSEL0, {29'h0, cs[i]});
      wrc(`DTC_IDX_CMP0, 32'hFF);
      wrc(`DTC_IDX_MODE0, 32'h80);
      if (i == 2) dtc_far_model_i.fire_irq(5);
      else dtc_far_model_i.pulse_pin(0, 5);
      repeat (8) @(posedge aclk);
      rdc("event count", `DTC_IDX_CNT0, 32'h5);
    end
    wrc(`DTC_IDX_MODE0, 32'h0);
    wrc(`DTC_IDX_CLKSEL1, {29'h0, DTC_CS_RISE});
    wrc(`DTC_IDX_CMP1, 32'h2);
    wrc(`DTC_IDX_MODE1, 32'h80);
    i1 = irq1_cnt;
    dtc_far_model_i.pulse_pin(1, 3);
    repeat (8) @(posedge aclk);
    chk("upper matches", 1, irq1_cnt - i1);
    rdc("upper count cleared", `DTC_IDX_CNT1, 32'h0);
    wrc(`DTC_IDX_MODE1, 32'h0);
    $display("test event done");
  endtask
  // 16-bit pair with the upper clock select pointed at a busy pin
  task automatic t_cascade;
    int t;
    int i1;
    wrc(`DTC_IDX_MODE1, 32'h10);
    wrc(`DTC_IDX_CLKSEL0, {29'h0, DTC_CS_FXX});
    wrc(`DTC_IDX_CLKSEL1, {29'h0, DTC_CS_RISE});
    wrc(`DTC_IDX_CCMP, 32'h0102);
    rdc("cascaded compare", `DTC_IDX_CCMP, 32'h0102);
    wrc(`DTC_IDX_MODE0, 32'h80);
    i1 = irq1_cnt;
    fork
      dtc_far_model_i.pulse_pin(1, 20);
      begin
        wait_irq(t);
        wait_irq(t);
      end
    join
    chk("cascade interval", 259, t);
    chk("upper silent", 0, irq1_cnt - i1);
    rdc("byte count hidden", `DTC_IDX_CNT0, 32'h0);
    wrc(`DTC_IDX_MODE0, 32'h0);
    rdc("cascaded count cleared", `DTC_IDX_CCNT, 32'h0);
    rdc("cascaded count again", `DTC_IDX_CCNT, 32'h0);
    wrc(`DTC_IDX_MODE1, 32'h0);
    $display("test cascade done");
  endtask
  // overflow sets the output, match clears it
  task automatic t_pwm;
    int t;
    int th;
    int tl;
    wrc(`DTC_IDX_CLKSEL0, {29'h0, DTC_CS_FXX});
    wrc(`DTC_IDX_CMP0, 32'h40);
    wrc(`DTC_IDX_MODE0, 32'hC1);
    pin_wait(1'h1, t);
    pin_wait(1'h0, th);
    pin_wait(1'h1, tl);
    chk("pwm period", 256, th + tl);
    chk("pwm high time", 1, {31'h0, th == 64 || th == 65});
    wrc(`DTC_IDX_MODE0, 32'h0);
    $display("test pwm done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_interval();
    t_event();
    t_cascade();
    t_pwm();
    complete_run();
  end
endmodule // dual_8bit_timer_cascade_tb
